// ===== rtl/phy_ctrl_pkg.sv
// Package: offsets, field positions, reset values and timing for the basic control register
package phy_ctrl_pkg;
	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [4:0] BASIC_PHY_CONTROL_OFFSET = 5'h00;
	localparam int BIT_SPEED = 13;
	localparam int BIT_AN_EN = 12;
	localparam int BIT_AN_RESTART = 9;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_COL_TEST = 7;
	localparam logic [15:0] WRITABLE_MASK = 16'h3180;
	localparam logic RST_SPEED = 1'b1;
	localparam logic RST_AN_EN = 1'b1;
	localparam logic RST_COL_TEST = 1'b0;
	localparam logic RST_AN_RESTART = 1'b0;
	// Strap pin not yet sampled
	localparam logic RST_DUPLEX = 1'b1;
	// Read image in reset with offset zero selected
	localparam logic [15:0] RST_CONTROL = 16'h3100;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_PS = 8000;
	// Bit time at 10 Mb/s, the slower rate, in ps
	localparam int BIT_TIME_PS = 100000;
	localparam int COL_ON_BITS = 512;
	localparam int COL_OFF_BITS = 4;
	// Longest times round down
	localparam int COL_ON_CYCLES = (COL_ON_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
	localparam int COL_OFF_CYCLES = (COL_OFF_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
	// Cycles from strap release to capture
	localparam int STRAP_SYNC_CYCLES = 3;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic an_enable;
	} link_mode_s;
endpackage

// ===== rtl/basic_phy_control.sv
// Basic PHY control register: restart, duplex, collision test, reserved bits
module basic_phy_control (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic duplex_strap_i,
	input wire logic an_started_i,
	output logic an_restart_o,
	input wire logic tx_en_i,
	output logic col_o,
	output logic forced_mode_valid_o,
	output phy_ctrl_pkg::link_mode_s link_mode_o
);
	// ************************************************************
	// Strap capture
	// ************************************************************
	logic [2:0] strap_sync_q, strap_sync_d;
	logic [1:0] strap_cnt_q, strap_cnt_d;
	logic strap_done_q, strap_done_d;

	always_comb begin
		strap_sync_d = {strap_sync_q[1:0], duplex_strap_i};
		strap_cnt_d = strap_cnt_q;
		strap_done_d = strap_done_q;
		if (!strap_done_q) begin
			strap_cnt_d = strap_cnt_q + 2'h1;
			if (32'(strap_cnt_q) == phy_ctrl_pkg::STRAP_SYNC_CYCLES - 1) begin
				strap_done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_sync_q <= 3'h0;
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (clk_en_i) begin
			strap_sync_q <= strap_sync_d;
			strap_cnt_q <= strap_cnt_d;
			strap_done_q <= strap_done_d;
		end
	end

	// ************************************************************
	// Write decode
	// ************************************************************
	logic wr_hit;

	always_comb begin
		wr_hit = reg_wr_i && (reg_addr_i == phy_ctrl_pkg::BASIC_PHY_CONTROL_OFFSET);
	end

	// ************************************************************
	// Forced mode fields
	// ************************************************************
	logic speed_q, speed_d;
	logic an_en_q, an_en_d;
	logic duplex_q, duplex_d;
	logic strap_take;

	always_comb begin
		strap_take = !strap_done_q;
		strap_take = strap_take && 32'(strap_cnt_q) == phy_ctrl_pkg::STRAP_SYNC_CYCLES - 1;
		strap_take = strap_take && strap_sync_q[2] == strap_sync_q[1];
		speed_d = speed_q;
		an_en_d = an_en_q;
		duplex_d = duplex_q;
		if (strap_take) begin
			duplex_d = strap_sync_q[2];
		end
		// Write wins over a late strap capture
		if (wr_hit) begin
			speed_d = reg_wdata_i[phy_ctrl_pkg::BIT_SPEED];
			an_en_d = reg_wdata_i[phy_ctrl_pkg::BIT_AN_EN];
			duplex_d = reg_wdata_i[phy_ctrl_pkg::BIT_DUPLEX];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			speed_q <= phy_ctrl_pkg::RST_SPEED;
			an_en_q <= phy_ctrl_pkg::RST_AN_EN;
			duplex_q <= phy_ctrl_pkg::RST_DUPLEX;
		end else if (clk_en_i) begin
			speed_q <= speed_d;
			an_en_q <= an_en_d;
			duplex_q <= duplex_d;
		end
	end

	// ************************************************************
	// Collision test enable
	// ************************************************************
	logic col_test_q, col_test_d;

	always_comb begin
		col_test_d = col_test_q;
		if (wr_hit) begin
			col_test_d = reg_wdata_i[phy_ctrl_pkg::BIT_COL_TEST];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			col_test_q <= phy_ctrl_pkg::RST_COL_TEST;
		end else if (clk_en_i) begin
			col_test_q <= col_test_d;
		end
	end

	// ************************************************************
	// Restart request
	// ************************************************************
	logic restart_q, restart_d;
	logic restart_req;

	always_comb begin
		// restart only with enable in same word
		restart_req = wr_hit && reg_wdata_i[phy_ctrl_pkg::BIT_AN_RESTART];
		restart_req = restart_req && reg_wdata_i[phy_ctrl_pkg::BIT_AN_EN];
		// a written zero leaves it pending
		restart_d = restart_q;
		if (restart_q && an_started_i) begin
			restart_d = 1'b0;
		end
		// Set wins so a fresh request is never lost
		if (restart_req) begin
			restart_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			restart_q <= phy_ctrl_pkg::RST_AN_RESTART;
		end else if (clk_en_i) begin
			restart_q <= restart_d;
		end
	end

	// ************************************************************
	// Read data register
	// ************************************************************
	// Built from next values so a read after a write is current
	logic [15:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = 16'h0000;
		if (reg_addr_i == phy_ctrl_pkg::BASIC_PHY_CONTROL_OFFSET) begin
			rdata_d[phy_ctrl_pkg::BIT_SPEED] = speed_d;
			rdata_d[phy_ctrl_pkg::BIT_AN_EN] = an_en_d;
			rdata_d[phy_ctrl_pkg::BIT_AN_RESTART] = restart_d;
			rdata_d[phy_ctrl_pkg::BIT_DUPLEX] = duplex_d;
			rdata_d[phy_ctrl_pkg::BIT_COL_TEST] = col_test_d;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// Reset image assumes offset zero is selected
			rdata_q <= phy_ctrl_pkg::RST_CONTROL;
		end else if (clk_en_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ************************************************************
	// Mode outputs
	// ************************************************************
	assign an_restart_o = restart_q;
	assign link_mode_o = '{speed_100: speed_q, full_duplex: duplex_q, an_enable: an_en_q};
	// forced bits only count when disabled
	assign forced_mode_valid_o = !an_en_q;

	// ************************************************************
	// Collision test
	// ************************************************************
	// Single flop path: far inside both bounds
	logic col_q, col_d;

	always_comb begin
		col_d = col_test_q && tx_en_i;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			col_q <= 1'b0;
		end else if (clk_en_i) begin
			col_q <= col_d;
		end
	end

	assign col_o = col_q;
endmodule

// ===== bench/phy_ctrl_props.sv
// Port assertions for the basic control register
module phy_ctrl_props (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic an_started_i,
	input wire logic an_restart_o,
	input wire logic tx_en_i,
	input wire logic col_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	wire hit = clk_en_i && reg_wr_i && reg_addr_i == 5'h00;
	wire setr = hit && reg_wdata_i[9];
	sequence s_wr; hit ##1 reg_addr_i == 5'h00; endsequence
	property p_go; setr && reg_wdata_i[12] |=> an_restart_o; endproperty
	a_go: assert property (p_go) else $error("restart lost");
	property p_ign; hit && !reg_wdata_i[12] && !an_restart_o |=> !an_restart_o; endproperty
	a_ign: assert property (p_ign) else $error("restart taken");
	property p_hold; an_restart_o && clk_en_i && !an_started_i |=> an_restart_o; endproperty
	a_hold: assert property (p_hold) else $error("restart dropped");
	property p_clr; clk_en_i && an_started_i && !setr |=> !an_restart_o; endproperty
	a_clr: assert property (p_clr) else $error("no self clear");
	property p_wr; s_wr |-> (reg_rdata_o & 16'h3180) == ($past(reg_wdata_i) & 16'h3180); endproperty
	a_wr: assert property (p_wr) else $error("bad field");
	property p_res; reg_rdata_o[6:0] == 7'h00; endproperty
	a_res: assert property (p_res) else $error("reserved set");
	property p_con; clk_en_i && tx_en_i && reg_addr_i == 5'h00 && reg_rdata_o[7] |=> col_o; endproperty
	a_con: assert property (p_con) else $error("no col");
	property p_coff; clk_en_i && !tx_en_i |=> !col_o; endproperty
	a_coff: assert property (p_coff) else $error("col stuck");
endmodule

// ===== bench/an_engine.sv
// Negotiation engine model answering restart requests
module an_engine (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic hold_i,
	input wire logic an_restart_i,
	output logic an_started_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) cnt_q <= 2'h0;
		else if (an_restart_i && !hold_i) cnt_q <= cnt_q + 2'h1;
		else cnt_q <= 2'h0;
	end
	assign an_started_o = cnt_q == 2'h3;
endmodule

// ===== bench/tb_basic_phy_control.sv
// Testbench for the basic control register
module tb_basic_phy_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, wr = 0, tx = 0, hold = 1, en = 1, strap = 1, st, rq, col, fv;
	logic [4:0] addr = 5'h00;
	logic [15:0] wd = 16'h0000, rd;
	phy_ctrl_pkg::link_mode_s lm;
	int mismatches = 0, check_count = 0;
	logic [15:0] rows [5][3] = '{'{16'h0280, 16'h0080, 16'h0008},
		'{16'h2100, 16'h2100, 16'h000e}, '{16'hc07f, 16'h0000, 16'h0008},
		'{16'h1200, 16'h1200, 16'h0001}, '{16'h1000, 16'h1200, 16'h0001}};
	always #4 clk = ~clk;
	basic_phy_control i_dut (.ref_clk_i(clk), .rstn_i(rstn), .clk_en_i(en),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rd),
		.duplex_strap_i(strap), .an_started_i(st), .an_restart_o(rq), .tx_en_i(tx),
		.col_o(col), .forced_mode_valid_o(fv), .link_mode_o(lm));
	an_engine i_eng (.ref_clk_i(clk), .rstn_i(rstn), .hold_i(hold), .an_restart_i(rq),
		.an_started_o(st));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wrt(input logic [15:0] d);
		@(posedge clk);
		#1;
		wr = 1;
		wd = d;
		@(posedge clk);
		#1;
		wr = 0;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 rstn = 1;
		chk(rd, 16'h3100);
		chk({14'h0, col, rq}, 16'h0000);
		repeat (5) @(posedge clk);
		#1 chk(rd, 16'h3100);
		foreach (rows[i]) begin
			wrt(rows[i][0]);
			chk(rd, rows[i][1]);
			chk({12'h000, fv, lm}, rows[i][2]);
		end
		// Engine stalled until now
		hold = 0;
		repeat (6) @(posedge clk);
		#1 chk(rd, 16'h1000);
		chk({15'h0, rq}, 16'h0000);
		wrt(16'h0080);
		tx = 1;
		@(posedge clk) #1 chk({15'h0, col}, 16'h0001);
		tx = 0;
		@(posedge clk) #1 chk({15'h0, col}, 16'h0000);
		// Frozen clock: write and transmit enable ignored
		en = 0;
		tx = 1;
		wrt(16'h2100);
		chk(rd, 16'h0080);
		chk({15'h0, col}, 16'h0000);
		en = 1;
		tx = 0;
		@(posedge clk) #1 addr = 5'h01;
		@(posedge clk) #1 chk(rd, 16'h0000);
		// Mid-run reset with the strap low
		rstn = 0;
		strap = 0;
		addr = 5'h00;
		#1 chk(rd, 16'h3100);
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		repeat (3) @(posedge clk);
		#1 chk(rd, 16'h3000);
		finish_test;
	end
	initial begin
		#5000;
		mismatches++;
		finish_test;
	end
endmodule
bind basic_phy_control phy_ctrl_props i_props (
	.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i),
	.clk_en_i(clk_en_i),
	.reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o),
	.an_started_i(an_started_i),
	.an_restart_o(an_restart_o),
	.tx_en_i(tx_en_i),
	.col_o(col_o)
);
